// [core/cbu_pkg.sv]
// What this block does
// - One shared datapath for equal, nonnegative and coprocessor branches
// - Coprocessor branch tests selected condition code
// - Target is delay-slot address plus shifted offset
// - Non-likely: slot runs, redirect only afterwards
// - Equal compare taken when both registers match
// - Likely forms nullify slot when not taken
// - Nonnegative condition is sign bit zero
// - Nonnegative branch decoded from register-immediate opcode
// - Link forms write branch address plus eight
// - Link-likely combines link write with nullify
// - Coprocessor branch raises unusable and reserved exceptions
// - Equal compare of register zero always taken
// - Link nonnegative on register zero always taken
package cbu_pkg;

  // Instruction field positions
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int RA_HI = 25;
  localparam int RA_LO = 21;
  localparam int RB_HI = 20;
  localparam int RB_LO = 16;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 0;
  localparam int CC_HI = 20;
  localparam int CC_LO = 18;
  localparam int ND_BIT = 17;
  localparam int TF_BIT = 16;
  localparam int SIGN_BIT = 31;

  // Primary opcodes
  localparam logic [5:0] OPC_REGISTER_IMMEDIATE_OPCODE = 6'h01;
  localparam logic [5:0] OPC_EQ = 6'h04;
  localparam logic [5:0] OPC_EQ_LIKELY = 6'h14;
  localparam logic [5:0] OPC_SECOND_COPROCESSOR = 6'h12;

  // Register-immediate sub-opcodes and coprocessor branch selector
  localparam logic [4:0] SUB_NONNEG = 5'h01;
  localparam logic [4:0] SUB_NONNEG_LIKELY = 5'h03;
  localparam logic [4:0] SUB_NONNEG_LINK = 5'h11;
  localparam logic [4:0] SUB_NONNEG_LINK_LIKELY = 5'h13;
  localparam logic [4:0] COP_BRANCH_SEL = 5'h08;

  // Register numbers and address steps
  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [4:0] LINK_REG = 5'h1f;
  localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
  localparam logic [31:0] LINK_STEP = 32'h0000_0008;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int OFS_EXT = 14;

  // Branch class from the decoder
  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_EQ = 2'b01,
    K_NONNEG = 2'b10,
    K_COP = 2'b11
  } cbu_kind_e;

  // Resolution state
  typedef enum logic {
    S_IDLE = 1'b0,
    S_SLOT = 1'b1
  } cbu_state_e;

endpackage : cbu_pkg

// [core/cbu_decode.sv]
module cbu_decode
  import cbu_pkg::*;
(
  input wire logic [31:0] instr,
  output cbu_kind_e kind,
  output logic likely,
  output logic link,
  output logic polarity_select,
  output logic [2:0] condition_select
);

  logic [5:0] opc;
  logic [4:0] sub;

  assign opc = instr[OPC_HI:OPC_LO];
  assign sub = instr[RB_HI:RB_LO];

  // Opcode to branch class, likely and link flags
  always_comb begin
    kind = K_NONE;
    likely = 1'b0;
    link = 1'b0;
    polarity_select = instr[TF_BIT];
    condition_select = instr[CC_HI:CC_LO];
    unique case (opc)
      OPC_EQ: begin
        kind = K_EQ;
      end
      OPC_EQ_LIKELY: begin
        kind = K_EQ;
        likely = 1'b1;
      end
      OPC_REGISTER_IMMEDIATE_OPCODE: begin
        unique case (sub)
          SUB_NONNEG: kind = K_NONNEG;
          SUB_NONNEG_LIKELY: begin
            kind = K_NONNEG;
            likely = 1'b1;
          end
          SUB_NONNEG_LINK: begin
            kind = K_NONNEG;
            link = 1'b1;
          end
          SUB_NONNEG_LINK_LIKELY: begin
            kind = K_NONNEG;
            link = 1'b1;
            likely = 1'b1;
          end
          default: kind = K_NONE;
        endcase
      end
      OPC_SECOND_COPROCESSOR: begin
        if (instr[RA_HI:RA_LO] == COP_BRANCH_SEL) begin
          kind = K_COP;
          likely = instr[ND_BIT];
        end
      end
      default: kind = K_NONE;
    endcase
  end

endmodule : cbu_decode

// [core/cbu_target.sv]
module cbu_target
  import cbu_pkg::*;
(
  input wire logic [31:0] branch_pc,
  input wire logic [15:0] offset,
  output logic [31:0] target,
  output logic [31:0] link_value
);

  logic [31:0] ext_offset;

  // Eighteen-bit signed offset widened to a word
  assign ext_offset = {{OFS_EXT{offset[IMM_HI]}}, offset, 2'b00};
  // Relative to the delay-slot instruction
  assign target = branch_pc + SLOT_STEP + ext_offset;
  // Second instruction after the branch
  assign link_value = branch_pc + LINK_STEP;

endmodule : cbu_target

// [core/cbu_branch_unit.sv]
module cbu_branch_unit
  import cbu_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Branch slot from the fetch and execute pipeline
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] branch_pc,
  // Register file read data
  input wire logic [31:0] reg_a_data,
  input wire logic [31:0] reg_b_data,
  // Coprocessor condition source
  input wire logic [7:0] cop_cond,
  input wire logic cop_usable,
  input wire logic cop_present,
  // Delay slot retire and flush events
  input wire logic slot_done,
  input wire logic flush,
  // Register file read indices
  output logic [4:0] source_reg_a,
  output logic [4:0] source_reg_b,
  // Branch status toward the pipeline
  output logic is_branch,
  output logic busy,
  output logic nullify_slot,
  // PC redirect
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  // Link register write
  output logic link_we,
  output logic [4:0] link_reg,
  output logic [31:0] link_data,
  // Exceptions
  output logic exc_cop_unusable,
  output logic exc_reserved
);

  // Whole state of the unit, registered as one word
  typedef struct packed {
    cbu_state_e st;
    logic taken;
    logic likely;
    logic [31:0] target;
    logic nullify;
    logic redirect_valid;
    logic [31:0] redirect_pc;
    logic link_we;
    logic [31:0] link_data;
    logic exc_cu;
    logic exc_ri;
  } cbu_state_s;

  // Resolution state and its next value
  cbu_state_s r;
  cbu_state_s next_r;

  // Decoder and target results
  cbu_kind_e kind;
  logic likely;
  logic link;
  logic polarity_select;
  logic [2:0] condition_select;
  logic [31:0] target;
  logic [31:0] link_value;
  // Operands after the register-zero rule and strobes
  logic [31:0] a_val;
  logic [31:0] b_val;
  logic cond;
  logic accept;
  logic fire;

  // Register read indices go straight to the register file
  assign source_reg_a = instr[RA_HI:RA_LO];
  assign source_reg_b = instr[RB_HI:RB_LO];

  cbu_decode u_decode (
    .instr(instr),
    .kind(kind),
    .likely(likely),
    .link(link),
    .polarity_select(polarity_select),
    .condition_select(condition_select)
  );

  cbu_target u_target (
    .branch_pc(branch_pc),
    .offset(instr[IMM_HI:IMM_LO]),
    .target(target),
    .link_value(link_value)
  );

  // Register zero reads as zero whatever the file returns
  assign a_val = (source_reg_a == ZERO_REG) ? ZERO_WORD : reg_a_data;
  assign b_val = (source_reg_b == ZERO_REG) ? ZERO_WORD : reg_b_data;

  // Branch condition per class
  always_comb begin
    cond = 1'b0;
    unique case (kind)
      K_EQ: cond = (a_val == b_val);
      K_NONNEG: cond = ~a_val[SIGN_BIT];
      K_COP: cond = (cop_cond[condition_select] == polarity_select);
      K_NONE: cond = 1'b0;
    endcase
  end

  // A new branch is only taken while no other is pending
  assign accept = issue_valid && (kind != K_NONE) && (r.st == S_IDLE);
  // Accepted and not trapped by the coprocessor checks
  assign fire = accept && !((kind == K_COP) && !(cop_present && cop_usable));

  // Handshake and registered outputs
  assign is_branch = issue_valid && (kind != K_NONE);
  assign busy = (r.st == S_SLOT);
  assign nullify_slot = r.nullify;
  assign redirect_valid = r.redirect_valid;
  assign redirect_pc = r.redirect_pc;
  assign link_we = r.link_we;
  assign link_reg = r.link_we ? LINK_REG : ZERO_REG;
  assign link_data = r.link_data;
  assign exc_cop_unusable = r.exc_cu;
  assign exc_reserved = r.exc_ri;

  // Next state: evaluate in the branch slot, redirect after the delay slot
  always_comb begin
    next_r = r;
    next_r.redirect_valid = 1'b0;
    next_r.link_we = 1'b0;
    next_r.exc_cu = 1'b0;
    next_r.exc_ri = 1'b0;
    unique case (r.st)
      S_IDLE: begin
        if (accept) begin
          // Missing coprocessor outranks a disabled one
          if ((kind == K_COP) && !cop_present) begin
            next_r.exc_ri = 1'b1;
          end else if ((kind == K_COP) && !cop_usable) begin
            next_r.exc_cu = 1'b1;
          end else begin
            next_r.st = S_SLOT;
            next_r.taken = cond;
            next_r.likely = likely;
            next_r.target = target;
            next_r.nullify = likely && !cond;
            // Source was sampled before this write lands
            next_r.link_we = link;
            next_r.link_data = link_value;
          end
        end
      end
      S_SLOT: begin
        // Flush wins over a retiring slot
        if (flush) begin
          next_r.st = S_IDLE;
          next_r.nullify = 1'b0;
        end else if (slot_done) begin
          next_r.st = S_IDLE;
          next_r.nullify = 1'b0;
          next_r.redirect_valid = r.taken;
          next_r.redirect_pc = r.target;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Checks on the resolution pipeline
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Helper terms for the checks
  logic [31:0] exp_target;
  logic [31:0] exp_link;
  logic exp_sign;
  logic exp_cop;
  logic is_link;
  logic is_likely;
  logic is_eq;
  logic is_nonneg;
  logic is_cop;
  logic eq_match;
  logic eq_zero;
  logic ra_zero;
  logic cu_trap;
  logic was_slot_done;
  logic [31:0] held_target;
  logic ri_trap;
  logic idle_other;

  // Reference values recomputed without the submodules
  assign exp_target = branch_pc + SLOT_STEP + {{OFS_EXT{instr[IMM_HI]}}, instr[IMM_HI:IMM_LO], 2'b00};
  assign exp_link = branch_pc + LINK_STEP;
  assign exp_sign = a_val[SIGN_BIT];
  assign exp_cop = cop_cond[instr[CC_HI:CC_LO]] == instr[TF_BIT];
  assign is_link = fire && link;
  assign is_likely = fire && likely;
  assign is_eq = fire && (kind == K_EQ);
  assign is_nonneg = fire && (kind == K_NONNEG);
  assign is_cop = fire && (kind == K_COP);
  assign eq_match = (reg_a_data == reg_b_data) && (source_reg_a != ZERO_REG) && (source_reg_b != ZERO_REG);
  assign eq_zero = (source_reg_a == ZERO_REG) && (source_reg_b == ZERO_REG);
  assign ra_zero = (source_reg_a == ZERO_REG);
  assign cu_trap = accept && (kind == K_COP) && cop_present && !cop_usable;
  assign was_slot_done = busy && slot_done && !flush;
  assign held_target = r.target;
  assign ri_trap = accept && (kind == K_COP) && !cop_present;
  assign idle_other = issue_valid && (kind == K_NONE) && !busy;

  // Named steps of a resolution
  sequence seq_slot_end;
    was_slot_done && r.taken;
  endsequence

  sequence seq_redirect;
    redirect_valid && (redirect_pc == $past(held_target));
  endsequence

  sequence seq_pending;
    busy && !slot_done && !flush;
  endsequence

  sequence seq_slot_skip;
    was_slot_done && !r.taken;
  endsequence

  // Issue-cycle results
  AST_LINK_VALUE: assert property (is_link |=> link_we && link_reg == LINK_REG && link_data == $past(exp_link))
    else $error("link write missing or wrong value");
  AST_TARGET: assert property (fire |=> busy && r.target == $past(exp_target))
    else $error("branch target wrong");
  AST_EQ_TAKEN: assert property (is_eq && eq_match |=> r.taken)
    else $error("equal compare not taken");
  AST_ZERO_EQ: assert property (is_eq && eq_zero |=> r.taken)
    else $error("register zero compare not taken");
  AST_NONNEG: assert property (is_nonneg |=> r.taken == !$past(exp_sign))
    else $error("nonnegative condition wrong");
  AST_ZERO_CALL: assert property (is_link && ra_zero |=> r.taken && link_we)
    else $error("zero source call not taken");
  AST_COP_COND: assert property (is_cop |=> r.taken == $past(exp_cop))
    else $error("coprocessor condition wrong");
  AST_LIKELY_NULL: assert property (is_likely |=> nullify_slot == !r.taken)
    else $error("likely nullify wrong");
  AST_PLAIN_RUNS: assert property (fire && !likely |=> !nullify_slot)
    else $error("non-likely slot nullified");

  // Resolution after the delay slot
  AST_REDIRECT: assert property (seq_slot_end |=> seq_redirect)
    else $error("redirect missing after delay slot");
  AST_NO_EARLY: assert property (redirect_valid |-> $past(was_slot_done))
    else $error("redirect before delay slot done");

  // Coprocessor traps and nullify span
  AST_CU_TRAP: assert property (cu_trap |=> exc_cop_unusable && !busy && !link_we)
    else $error("coprocessor unusable not raised");
  AST_NULL_SPAN: assert property (seq_pending ##0 nullify_slot |=> nullify_slot)
    else $error("nullify dropped while pending");
  AST_RI_TRAP: assert property (ri_trap |=> exc_reserved && !exc_cop_unusable && !busy && !link_we)
    else $error("reserved instruction not raised");
  AST_RI_CAUSE: assert property (exc_reserved |-> $past(ri_trap))
    else $error("reserved instruction without cause");
  AST_CU_CAUSE: assert property (exc_cop_unusable |-> $past(cu_trap))
    else $error("coprocessor unusable without cause");
  AST_COP_NULL: assert property (is_cop |=> nullify_slot == ($past(instr[ND_BIT]) && !r.taken))
    else $error("coprocessor nullify select wrong");

  // Pending branch holds until its delay slot ends
  AST_BUSY_HOLD: assert property (seq_pending |=> busy && r.target == $past(held_target))
    else $error("pending branch lost");
  AST_NO_NEST: assert property (seq_pending ##0 issue_valid |=> !link_we && !exc_cop_unusable && !exc_reserved)
    else $error("branch accepted while pending");
  AST_NULL_BUSY: assert property (nullify_slot |-> busy && r.likely && !r.taken)
    else $error("nullify outside a likely not-taken branch");
  AST_PLAIN_KEEP: assert property (busy && !r.likely |-> !nullify_slot)
    else $error("non-likely slot nullified while pending");

  // Resolution ends, taken or not, and flush
  AST_NOT_TAKEN: assert property (seq_slot_skip |=> !redirect_valid && !busy && !nullify_slot)
    else $error("redirect for a branch not taken");
  AST_FLUSH_DROP: assert property (busy && flush |=> !busy && !redirect_valid && !nullify_slot)
    else $error("flush did not drop the branch");
  AST_REDIR_PULSE: assert property (redirect_valid |=> !redirect_valid)
    else $error("redirect longer than one cycle");

  // Link pulse, register zero and unhandled encodings
  AST_LINK_PULSE: assert property (link_we |=> !link_we)
    else $error("link write longer than one cycle");
  AST_ZERO_SRC: assert property (is_nonneg && ra_zero |=> r.taken)
    else $error("register zero source not read as zero");
  AST_IGNORE: assert property (idle_other |=> !busy && !link_we && !exc_cop_unusable && !exc_reserved)
    else $error("unhandled encoding acted on");

endmodule : cbu_branch_unit

// [verification/cbu_pipe_model.sv]
module cbu_pipe_model
  import cbu_pkg::*;
(
  input wire logic mclk,
  input wire logic busy,
  input wire logic [4:0] source_reg_a,
  input wire logic [4:0] source_reg_b,
  input wire logic [3:0] slot_wait,
  output logic [31:0] reg_a_data,
  output logic [31:0] reg_b_data,
  output logic slot_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [32];
  logic [3:0] cnt = 4'h0;
  // Raw register file read; register zero may hold garbage here
  assign reg_a_data = regs[source_reg_a];
  assign reg_b_data = regs[source_reg_b];
  // Delay slot retires slot_wait+1 cycles after the branch goes pending
  initial slot_done = 1'b0;
  always @(negedge mclk) begin
    slot_done <= 1'b0;
    if (busy && !slot_done) begin
      if (cnt == slot_wait) begin
        slot_done <= 1'b1;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule : cbu_pipe_model

// [verification/cbu_branch_unit_bench.sv]
module cbu_branch_unit_bench;
  import cbu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, cop_usable = 1'b1, cop_present = 1'b1, flush = 1'b0;
  logic [31:0] instr = 32'h0000_0000, branch_pc = 32'h0000_0000;
  logic [7:0] cop_cond = 8'h00;
  logic [3:0] slot_wait = 4'h0;
  logic [31:0] reg_a_data, reg_b_data, redirect_pc, link_data;
  logic [4:0] source_reg_a, source_reg_b, link_reg;
  logic slot_done, is_branch, busy, nullify_slot, redirect_valid, link_we, exc_cop_unusable, exc_reserved;
  int miscompares = 0;
  int n_compared = 0;
  always #5 mclk = ~mclk;
  cbu_branch_unit i_cbu_branch_unit (.mclk, .rst_n, .issue_valid, .instr, .branch_pc, .reg_a_data, .reg_b_data,
    .cop_cond, .cop_usable, .cop_present, .slot_done, .flush, .source_reg_a, .source_reg_b, .is_branch, .busy,
    .nullify_slot, .redirect_valid, .redirect_pc, .link_we, .link_reg, .link_data, .exc_cop_unusable, .exc_reserved);
  cbu_pipe_model i_cbu_pipe_model (.mclk, .busy, .source_reg_a, .source_reg_b, .slot_wait, .reg_a_data,
    .reg_b_data, .slot_done);
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  function logic [31:0] enc(input logic [5:0] op, input logic [4:0] a, input logic [4:0] b, input logic [15:0] o);
    return {op, a, b, o};
  endfunction : enc
  // Issue one branch, check the cycle after, then follow it to resolution
  task run_br(input logic [31:0] ins, input logic [31:0] pc, input logic tk, input logic nl, input logic lk,
              input logic [1:0] ex);
    logic seen;
    logic [31:0] rpc;
    int i;
    seen = 1'b0;
    rpc = 32'h0000_0000;
    @(negedge mclk);
    issue_valid = 1'b1;
    instr = ins;
    branch_pc = pc;
    #1 chk(is_branch, 1'b1);
    chk({source_reg_a, source_reg_b}, ins[25:16]);
    @(negedge mclk);
    issue_valid = 1'b0;
    chk(busy, ex == 2'd0);
    chk(nullify_slot, nl);
    chk(link_we, lk);
    chk(link_reg, lk ? LINK_REG : ZERO_REG);
    if (lk) chk(link_data, pc + 32'h0000_0008);
    chk(exc_cop_unusable, ex == 2'd1);
    chk(exc_reserved, ex == 2'd2);
    for (i = 0; i < 20 && busy; i++) begin
      @(negedge mclk);
      if (redirect_valid) begin
        seen = 1'b1;
        rpc = redirect_pc;
      end
    end
    chk(busy, 1'b0);
    chk(seen, tk);
    if (tk) chk(rpc, pc + 32'h0000_0004 + {{14{ins[15]}}, ins[15:0], 2'b00});
    @(negedge mclk);
    chk(redirect_valid, 1'b0);
  endtask : run_br
  task t_equal;
    i_cbu_pipe_model.regs[0] = 32'hffff_fff0;
    i_cbu_pipe_model.regs[3] = 32'h1234_5678;
    i_cbu_pipe_model.regs[4] = 32'h1234_5678;
    i_cbu_pipe_model.regs[5] = 32'h1234_5679;
    i_cbu_pipe_model.regs[6] = 32'h0000_0000;
    run_br(enc(OPC_EQ, 5'd3, 5'd4, 16'hfffe), 32'h0000_1000, 1'b1, 1'b0, 1'b0, 2'd0);
    run_br(enc(OPC_EQ, 5'd3, 5'd5, 16'h0010), 32'h0000_2000, 1'b0, 1'b0, 1'b0, 2'd0);
    run_br(enc(OPC_EQ, 5'd0, 5'd0, 16'h8000), 32'h0004_0000, 1'b1, 1'b0, 1'b0, 2'd0);
    run_br(enc(OPC_EQ, 5'd0, 5'd6, 16'h0001), 32'h0000_3000, 1'b1, 1'b0, 1'b0, 2'd0);
    run_br(enc(OPC_EQ_LIKELY, 5'd3, 5'd5, 16'h0020), 32'h0000_4000, 1'b0, 1'b1, 1'b0, 2'd0);
    run_br(enc(OPC_EQ_LIKELY, 5'd3, 5'd4, 16'h0020), 32'h0000_5000, 1'b1, 1'b0, 1'b0, 2'd0);
    $display("test equal done");
  endtask : t_equal
  // All four nonnegative forms; source 31 is never used as a link source
  task t_nonneg;
    logic [4:0] subs [4];
    logic [4:0] s;
    int i;
    subs = '{SUB_NONNEG, SUB_NONNEG_LIKELY, SUB_NONNEG_LINK, SUB_NONNEG_LINK_LIKELY};
    i_cbu_pipe_model.regs[0] = 32'h8000_0001;
    i_cbu_pipe_model.regs[7] = 32'h0000_0000;
    i_cbu_pipe_model.regs[8] = 32'h8000_0000;
    for (i = 0; i < 4; i++) begin
      s = subs[i];
      slot_wait = 4'(i * 2);
      run_br(enc(OPC_REGISTER_IMMEDIATE_OPCODE, 5'd7, s, 16'h7fff), 32'h0001_0000, 1'b1, 1'b0, s[4], 2'd0);
      run_br(enc(OPC_REGISTER_IMMEDIATE_OPCODE, 5'd8, s, 16'h0004), 32'h0001_0100, 1'b0, s[1], s[4], 2'd0);
      run_br(enc(OPC_REGISTER_IMMEDIATE_OPCODE, 5'd0, s, 16'hff00), 32'h0001_0200, 1'b1, 1'b0, s[4], 2'd0);
    end
    slot_wait = 4'h0;
    $display("test nonnegative done");
  endtask : t_nonneg
  // Every condition code with both polarities, nullify bit set on half of them, then the traps
  task t_cop;
    logic [2:0] cc;
    logic tf, nd, tk;
    int j;
    for (j = 0; j < 16; j++) begin
      cc = j[2:0];
      tf = j[3];
      nd = j[0] ^ j[3];
      tk = (j[1] == tf);
      cop_cond = j[1] ? (8'h01 << cc) : ~(8'h01 << cc);
      run_br({OPC_SECOND_COPROCESSOR, COP_BRANCH_SEL, cc, nd, tf, 16'h0040}, 32'h0002_0000, tk, nd & !tk, 1'b0, 2'd0);
    end
    cop_usable = 1'b0;
    run_br({OPC_SECOND_COPROCESSOR, COP_BRANCH_SEL, 5'h03, 16'h0040}, 32'h0002_0100, 1'b0, 1'b0, 1'b0, 2'd1);
    cop_present = 1'b0;
    run_br({OPC_SECOND_COPROCESSOR, COP_BRANCH_SEL, 5'h03, 16'h0040}, 32'h0002_0200, 1'b0, 1'b0, 1'b0, 2'd2);
    cop_usable = 1'b1;
    cop_present = 1'b1;
    $display("test coprocessor done");
  endtask : t_cop
  // A flush while pending drops the redirect
  task t_flush;
    int i;
    slot_wait = 4'ha;
    @(negedge mclk);
    issue_valid = 1'b1;
    instr = enc(OPC_EQ, 5'd3, 5'd4, 16'h0008);
    @(negedge mclk);
    instr = enc(OPC_REGISTER_IMMEDIATE_OPCODE, 5'd7, SUB_NONNEG_LINK, 16'h0008);
    chk(busy, 1'b1);
    @(negedge mclk);
    issue_valid = 1'b0;
    chk({busy, link_we}, 2'b10);
    flush = 1'b1;
    @(negedge mclk);
    flush = 1'b0;
    for (i = 0; i < 15; i++) begin
      @(negedge mclk);
      chk({busy, redirect_valid}, 2'b00);
    end
    slot_wait = 4'h0;
    $display("test flush done");
  endtask : t_flush
  // Encodings outside the handled set raise nothing
  task t_refuse;
    @(negedge mclk);
    issue_valid = 1'b1;
    instr = enc(OPC_REGISTER_IMMEDIATE_OPCODE, 5'd7, 5'h00, 16'h0010);
    #1 chk(is_branch, 1'b0);
    @(negedge mclk);
    instr = enc(OPC_SECOND_COPROCESSOR, 5'h00, 5'h00, 16'h0010);
    #1 chk(is_branch, 1'b0);
    chk({busy, link_we, exc_cop_unusable, exc_reserved}, 4'h0);
    @(negedge mclk);
    issue_valid = 1'b0;
    chk({busy, link_we, exc_cop_unusable, exc_reserved}, 4'h0);
    $display("test refuse done");
  endtask : t_refuse
  // Main sequence
  initial begin
    repeat (4) @(negedge mclk);
    chk({busy, nullify_slot, redirect_valid, link_we, link_reg}, 9'h000);
    rst_n = 1'b1;
    t_equal();
    t_nonneg();
    t_cop();
    t_flush();
    t_refuse();
    finish_test();
  end
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule : cbu_branch_unit_bench
